// [core/tpw_pkg.sv]
// package of register offsets, field positions, reset values and timing
// assumes a 32-bit avalon-mm slave with byte addresses, one word per register
package tpw_pkg;

  // ****************************************************************
  // register byte offsets
  // ****************************************************************
  localparam logic [5:0] OFS_PIN_EDGE_CTRL    = 6'h00;
  localparam logic [5:0] OFS_THIRD_TIMER_CTRL = 6'h04;
  localparam logic [5:0] OFS_FOURTH_TIMER_CTRL = 6'h08;
  localparam logic [5:0] OFS_MEASURE_CTRL     = 6'h0C;
  localparam logic [5:0] OFS_FIRST_TIMER_CTRL = 6'h10;
  localparam logic [5:0] OFS_SECOND_TIMER_CTRL = 6'h14;
  localparam logic [5:0] OFS_FIRST_TIMER_RELOAD = 6'h18;
  localparam logic [5:0] OFS_SECOND_TIMER_RELOAD = 6'h1C;
  localparam logic [5:0] OFS_THIRD_TIMER_RELOAD = 6'h20;
  localparam logic [5:0] OFS_LOW_PHASE_RELOAD = 6'h24;
  localparam logic [5:0] OFS_HIGH_PHASE_RELOAD = 6'h28;
  localparam logic [5:0] OFS_TIMER_FLAGS      = 6'h2C;
  localparam logic [5:0] OFS_TIMER_COUNTS     = 6'h30;

  // ****************************************************************
  // field positions
  // ****************************************************************
  localparam int PE_PIN_A_OUT   = 0;  // pin a: 0 count input, 1 divided output
  localparam int PE_T3_GATE     = 1;  // timer 3 underflow gates pwm output
  localparam int PE_PIN_A_EDGE  = 2;  // 0 rising, 1 falling
  localparam int PE_PIN_B_EDGE  = 3;  // 0 rising, 1 falling
  localparam int TC_SRC_PIN     = 0;  // timers 1..3: count source is pin / t1
  localparam int TC_OUT_SEL_T2  = 1;  // second ctrl: pin a shows timer 2
  localparam int TC_RUN         = 2;  // timers 1..3 run bit
  localparam int T4_SRC_SLOW    = 0;
  localparam int T4_RUN         = 1;
  localparam int T4_HIGH_EXT    = 2;
  localparam int T4_PWM_OUT     = 3;
  localparam int MC_RUN         = 2;  // measurement run
  localparam int FL_PWM_LEVEL   = 4;
  localparam int FL_PWM_PASS    = 5;
  localparam int FL_MEAS_DONE   = 6;
  localparam int NUM_TIMERS     = 4;

  // ****************************************************************
  // reset values and timing
  // ****************************************************************
  localparam logic [3:0] CTRL_RESET   = 4'h0;
  localparam logic [7:0] RELOAD_RESET = 8'h00;
  localparam logic [7:0] COUNT_ZERO   = 8'h00;
  localparam logic [1:0] T4_DIV_FAST  = 2'h1;  // source period minus one, 2 clocks
  localparam logic [1:0] T4_DIV_SLOW  = 2'h3;  // source period minus one, 4 clocks
  localparam logic [1:0] T4_PH_RISE   = 2'h0;

  // measurement states, one-hot
  typedef enum logic [2:0] {
    MEAS_WAIT  = 3'h1,
    MEAS_COUNT = 3'h2,
    MEAS_DONE  = 3'h4
  } tpw_meas_e;

endpackage : tpw_pkg

// [core/tpw_edge.sv]
// edge detector for one timer pin, selectable rising or falling
// assumes the pin input is synchronous to clock
`timescale 1ns/1ps
`default_nettype none
module tpw_edge (
  // clock and reset
  input  wire logic clock,
  input  wire logic srst,
  // pin and selection
  input  wire logic pin_in,
  input  wire logic falling,
  // one-cycle pulse on the chosen edge
  output logic      edge_pulse
);

  logic prev_q;

  // ****************************************************************
  // previous level
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= pin_in;
    end
  end

  // edge choice
  assign edge_pulse = falling ? (prev_q & ~pin_in) : (~prev_q & pin_in);

endmodule : tpw_edge
`default_nettype wire

// [core/tpw_down.sv]
// 8-bit down counter with reload, for timers 1 to 3
// assumes count_pulse is a one-cycle source edge
`timescale 1ns/1ps
`default_nettype none
module tpw_down (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // control
  input  wire logic       run,
  input  wire logic       count_pulse,
  input  wire logic [7:0] reload,
  // state
  output logic [7:0]      count_q,
  output logic            underflow
);

  // underflow when a pulse meets zero
  assign underflow = run & count_pulse & (count_q == tpw_pkg::COUNT_ZERO);

  // ****************************************************************
  // counter; stopped timer holds its reload value
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      count_q <= tpw_pkg::RELOAD_RESET;
    end else if (!run) begin
      count_q <= reload;
    end else if (underflow) begin
      count_q <= reload;
    end else if (count_pulse) begin
      count_q <= count_q - 8'h01;
    end
  end

endmodule : tpw_down
`default_nettype wire

// [core/tpw_top.sv]
// timer pins, timer 1..4 counting, timer 4 pwm and underflow flags
// assumes an avalon-mm master on clock; pins synchronous to clock
//
// Overview of operation
// - pin a takes timer 1 count source or outputs timer 1/2 underflow halved.
// - pin b takes timer 3 count source or outputs timer 4 pwm.
// - pin control bit 0 picks pin a role; timer 4 bit 3 enables pwm on b.
// - timer 1 from pin a counts rising or falling edges per bit 2.
// - timer 3 from pin b counts rising or falling edges per bit 3.
// - with pwm on, timer 4 reloads alternately low and high each underflow.
// - pwm low length from low reload, high from high reload, driven on pin b.
// - extension bit lengthens high phase by half a source period, n plus 1.5.
// - gate bit set: each timer 3 underflow toggles pwm pass or block.
// - gating stops acting once timer 3 run bit is cleared.
// - clearing timer 4 run during high phase stops it only at next underflow.
// - each timer sets its own flag on underflow, readable by software.
// - flag clears when its interrupt is taken or a skip test clears it; here a write of one to its bit clears it.
// - while measuring, timer 1 flag marks measurement done, not underflow.
// - timers 1 to 3 start counting at first rising source edge after start; here they count from the first count pulse once the run bit is set.
// - timer 4 starts at rising edge following first falling edge after start.
// - low reload n divides timer 4 source by n plus one, zero to 255.
//
// Design decisions made here: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module tpw_top (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // avalon-mm slave
  input  wire logic [5:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic [31:0]      readdata,
  output logic             waitrequest,
  // first timer pin
  input  wire logic        timer_io_pin_a_in,
  output logic             timer_io_pin_a_out,
  output logic             timer_io_pin_a_oe,
  // second timer pin
  input  wire logic        timer_io_pin_b_in,
  output logic             timer_io_pin_b_out,
  output logic             timer_io_pin_b_oe,
  // flags toward the interrupt controller, and taken acknowledges
  input  wire logic [3:0]  irq_taken,
  output logic [3:0]       timer_flags
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  logic [3:0]  pin_edge_ctrl_q;
  logic [3:0]  first_timer_ctrl_q;
  logic [3:0]  second_timer_ctrl_q;
  logic [3:0]  third_timer_ctrl_q;
  logic [3:0]  fourth_timer_ctrl_q;
  logic [3:0]  measure_ctrl_q;
  logic [7:0]  reload_q [0:2];
  logic [7:0]  low_phase_reload_q;
  logic [7:0]  high_phase_reload_q;
  logic [3:0]  flags_q;
  logic [3:0]  flag_set;
  logic [3:0]  flag_clr;
  logic        wait_q;
  logic [31:0] rdata_q;
  logic        accept;
  logic        wr_low;
  logic        edge_a;
  logic        edge_b;
  logic        pulse_t1;
  logic        pulse_t2;
  logic        pulse_t3;
  logic        run_t1;
  logic [7:0]  cnt_t1;
  logic [7:0]  cnt_t2;
  logic [7:0]  cnt_t3;
  logic        uf_t1;
  logic        uf_t2;
  logic        uf_t3;
  logic        uf_t4;
  logic        div_a_q;
  logic        pass_q;
  logic        gate_active;
  logic        pin_a_out_q;
  logic        pin_a_oe_q;
  logic        pin_b_out_q;
  logic        pin_b_oe_q;
  tpw_pkg::tpw_meas_e meas_q;
  logic        meas_done;
  logic [1:0]  t4_ph_q;
  logic [1:0]  t4_ph_max;
  logic        t4_rise;
  logic        t4_fall;
  logic        t4_active_q;
  logic        t4_armed_q;
  logic        t4_high_q;
  logic        t4_ext_pend_q;
  logic [7:0]  t4_cnt_q;
  logic        t4_run_prev_q;
  logic        t4_zero_rise;
  logic        t4_ext_now;
  logic        t4_half_q;
  logic        t4_tick;

  // register select decode, used by write and read paths
  function automatic logic hit(input logic [5:0] a, input logic [5:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // ****************************************************************
  // avalon slave: one wait cycle, then accept
  // ****************************************************************
  assign accept = (read | write) & ~wait_q;
  assign wr_low = write & ~wait_q & byteenable[0];

  // waitrequest low for exactly one cycle per request
  always_ff @(posedge clock) begin
    if (srst) begin
      wait_q <= 1'b1;
    end else if ((read | write) && wait_q) begin
      wait_q <= 1'b0;
    end else begin
      wait_q <= 1'b1;
    end
  end

  // read data captured while waiting, stands at the accepting edge
  always_ff @(posedge clock) begin
    if (srst) begin
      rdata_q <= 32'h0000_0000;
    end else if (read && wait_q) begin
      case (1'b1)
        hit(address, tpw_pkg::OFS_PIN_EDGE_CTRL):     rdata_q <= {28'h0, pin_edge_ctrl_q};
        hit(address, tpw_pkg::OFS_THIRD_TIMER_CTRL):  rdata_q <= {28'h0, third_timer_ctrl_q};
        hit(address, tpw_pkg::OFS_FOURTH_TIMER_CTRL): rdata_q <= {28'h0, fourth_timer_ctrl_q};
        hit(address, tpw_pkg::OFS_MEASURE_CTRL):      rdata_q <= {28'h0, measure_ctrl_q};
        hit(address, tpw_pkg::OFS_FIRST_TIMER_CTRL):  rdata_q <= {28'h0, first_timer_ctrl_q};
        hit(address, tpw_pkg::OFS_SECOND_TIMER_CTRL): rdata_q <= {28'h0, second_timer_ctrl_q};
        hit(address, tpw_pkg::OFS_FIRST_TIMER_RELOAD): rdata_q <= {24'h0, reload_q[0]};
        hit(address, tpw_pkg::OFS_SECOND_TIMER_RELOAD): rdata_q <= {24'h0, reload_q[1]};
        hit(address, tpw_pkg::OFS_THIRD_TIMER_RELOAD): rdata_q <= {24'h0, reload_q[2]};
        hit(address, tpw_pkg::OFS_LOW_PHASE_RELOAD):  rdata_q <= {24'h0, low_phase_reload_q};
        hit(address, tpw_pkg::OFS_HIGH_PHASE_RELOAD): rdata_q <= {24'h0, high_phase_reload_q};
        hit(address, tpw_pkg::OFS_TIMER_FLAGS):
          rdata_q <= {25'h0, (meas_q == tpw_pkg::MEAS_DONE), pass_q, pin_b_out_q, flags_q};
        hit(address, tpw_pkg::OFS_TIMER_COUNTS):      rdata_q <= {t4_cnt_q, cnt_t3, cnt_t2, cnt_t1};
        default:                                      rdata_q <= 32'h0000_0000;
      endcase
    end
  end

  // control registers, written at the accepting edge
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_edge_ctrl_q     <= tpw_pkg::CTRL_RESET;
      first_timer_ctrl_q  <= tpw_pkg::CTRL_RESET;
      second_timer_ctrl_q <= tpw_pkg::CTRL_RESET;
      third_timer_ctrl_q  <= tpw_pkg::CTRL_RESET;
      fourth_timer_ctrl_q <= tpw_pkg::CTRL_RESET;
      measure_ctrl_q      <= tpw_pkg::CTRL_RESET;
    end else if (wr_low) begin
      if (hit(address, tpw_pkg::OFS_PIN_EDGE_CTRL)) pin_edge_ctrl_q <= writedata[3:0];
      if (hit(address, tpw_pkg::OFS_FIRST_TIMER_CTRL)) first_timer_ctrl_q <= writedata[3:0];
      if (hit(address, tpw_pkg::OFS_SECOND_TIMER_CTRL)) second_timer_ctrl_q <= writedata[3:0];
      if (hit(address, tpw_pkg::OFS_THIRD_TIMER_CTRL)) third_timer_ctrl_q <= writedata[3:0];
      if (hit(address, tpw_pkg::OFS_FOURTH_TIMER_CTRL)) fourth_timer_ctrl_q <= writedata[3:0];
      if (hit(address, tpw_pkg::OFS_MEASURE_CTRL)) measure_ctrl_q <= writedata[3:0];
    end
  end

  // reload registers; writes at an underflow are the software's to avoid
  always_ff @(posedge clock) begin
    if (srst) begin
      reload_q[0]         <= tpw_pkg::RELOAD_RESET;
      reload_q[1]         <= tpw_pkg::RELOAD_RESET;
      reload_q[2]         <= tpw_pkg::RELOAD_RESET;
      low_phase_reload_q  <= tpw_pkg::RELOAD_RESET;
      high_phase_reload_q <= tpw_pkg::RELOAD_RESET;
    end else if (wr_low) begin
      if (hit(address, tpw_pkg::OFS_FIRST_TIMER_RELOAD)) reload_q[0] <= writedata[7:0];
      if (hit(address, tpw_pkg::OFS_SECOND_TIMER_RELOAD)) reload_q[1] <= writedata[7:0];
      if (hit(address, tpw_pkg::OFS_THIRD_TIMER_RELOAD)) reload_q[2] <= writedata[7:0];
      if (hit(address, tpw_pkg::OFS_LOW_PHASE_RELOAD)) low_phase_reload_q <= writedata[7:0];
      if (hit(address, tpw_pkg::OFS_HIGH_PHASE_RELOAD)) high_phase_reload_q <= writedata[7:0];
    end
  end

  assign readdata    = rdata_q;
  assign waitrequest = wait_q;

  // ****************************************************************
  // pin edges and timers 1 to 3
  // ****************************************************************
  tpw_edge u_edge_a (
    .clock      (clock),
    .srst       (srst),
    .pin_in     (timer_io_pin_a_in),
    .falling    (pin_edge_ctrl_q[tpw_pkg::PE_PIN_A_EDGE]),
    .edge_pulse (edge_a)
  );

  tpw_edge u_edge_b (
    .clock      (clock),
    .srst       (srst),
    .pin_in     (timer_io_pin_b_in),
    .falling    (pin_edge_ctrl_q[tpw_pkg::PE_PIN_B_EDGE]),
    .edge_pulse (edge_b)
  );

  // source selection; pin a counts only while it is an input
  assign pulse_t1 = first_timer_ctrl_q[tpw_pkg::TC_SRC_PIN]
                    ? (edge_a & ~pin_edge_ctrl_q[tpw_pkg::PE_PIN_A_OUT]) : 1'b1;
  assign pulse_t3 = third_timer_ctrl_q[tpw_pkg::TC_SRC_PIN]
                    ? (edge_b & ~fourth_timer_ctrl_q[tpw_pkg::T4_PWM_OUT]) : 1'b1;
  assign pulse_t2 = second_timer_ctrl_q[tpw_pkg::TC_SRC_PIN] ? uf_t1 : 1'b1;

  // while measuring, timer 1 counts only between the two target edges
  assign run_t1 = first_timer_ctrl_q[tpw_pkg::TC_RUN]
                  & (~measure_ctrl_q[tpw_pkg::MC_RUN] | (meas_q == tpw_pkg::MEAS_COUNT));

  tpw_down u_t1 (
    .clock       (clock),
    .srst        (srst),
    .run         (run_t1),
    .count_pulse (pulse_t1),
    .reload      (reload_q[0]),
    .count_q     (cnt_t1),
    .underflow   (uf_t1)
  );

  tpw_down u_t2 (
    .clock       (clock),
    .srst        (srst),
    .run         (second_timer_ctrl_q[tpw_pkg::TC_RUN]),
    .count_pulse (pulse_t2),
    .reload      (reload_q[1]),
    .count_q     (cnt_t2),
    .underflow   (uf_t2)
  );

  tpw_down u_t3 (
    .clock       (clock),
    .srst        (srst),
    .run         (third_timer_ctrl_q[tpw_pkg::TC_RUN]),
    .count_pulse (pulse_t3),
    .reload      (reload_q[2]),
    .count_q     (cnt_t3),
    .underflow   (uf_t3)
  );

  // ****************************************************************
  // period measurement: timer 1 runs between two target edges
  // ****************************************************************
  assign meas_done = (meas_q == tpw_pkg::MEAS_COUNT) & edge_a;

  always_ff @(posedge clock) begin
    if (srst) begin
      meas_q <= tpw_pkg::MEAS_WAIT;
    end else if (!measure_ctrl_q[tpw_pkg::MC_RUN]) begin
      meas_q <= tpw_pkg::MEAS_WAIT;
    end else begin
      case (meas_q)
        tpw_pkg::MEAS_WAIT:  if (edge_a && first_timer_ctrl_q[tpw_pkg::TC_RUN]) meas_q <= tpw_pkg::MEAS_COUNT;
        tpw_pkg::MEAS_COUNT: if (edge_a) meas_q <= tpw_pkg::MEAS_DONE;
        tpw_pkg::MEAS_DONE:  meas_q <= tpw_pkg::MEAS_DONE;  // done state held until rerun; timer 1 count returns to reload
        default:             meas_q <= tpw_pkg::MEAS_WAIT;
      endcase
    end
  end

  // ****************************************************************
  // underflow flags: set wins over clear
  // ****************************************************************
  assign flag_set = {uf_t4, uf_t3, uf_t2,
                     measure_ctrl_q[tpw_pkg::MC_RUN] ? meas_done : uf_t1};
  assign flag_clr = irq_taken
                    | ({4{wr_low & hit(address, tpw_pkg::OFS_TIMER_FLAGS)}} & writedata[3:0]);

  genvar gi;
  generate
    for (gi = 0; gi < tpw_pkg::NUM_TIMERS; gi = gi + 1) begin : g_flag
      always_ff @(posedge clock) begin
        if (srst) begin
          flags_q[gi] <= 1'b0;
        end else if (flag_set[gi]) begin
          flags_q[gi] <= 1'b1;
        end else if (flag_clr[gi]) begin
          flags_q[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  assign timer_flags = flags_q;

  // ****************************************************************
  // timer 4 source: rise and fall ticks of a divided clock
  // ****************************************************************
  assign t4_ph_max = fourth_timer_ctrl_q[tpw_pkg::T4_SRC_SLOW] ? tpw_pkg::T4_DIV_SLOW : tpw_pkg::T4_DIV_FAST;
  assign t4_rise   = (t4_ph_q == tpw_pkg::T4_PH_RISE);
  assign t4_fall   = (t4_ph_q == (t4_ph_max >> 1) + 2'h1);

  always_ff @(posedge clock) begin
    if (srst) begin
      t4_ph_q <= tpw_pkg::T4_PH_RISE;
    end else if (t4_ph_q >= t4_ph_max) begin
      t4_ph_q <= tpw_pkg::T4_PH_RISE;
    end else begin
      t4_ph_q <= t4_ph_q + 2'h1;
    end
  end

  // ****************************************************************
  // timer 4 counter and pwm phase
  // ****************************************************************
  // after each extended high phase the count edge swaps between source rise and fall
  assign t4_tick      = t4_half_q ? t4_fall : t4_rise;
  assign t4_zero_rise = t4_active_q & t4_armed_q & ~t4_ext_pend_q & t4_tick & (t4_cnt_q == tpw_pkg::COUNT_ZERO);
  assign t4_ext_now   = t4_high_q & fourth_timer_ctrl_q[tpw_pkg::T4_HIGH_EXT]
                        & fourth_timer_ctrl_q[tpw_pkg::T4_PWM_OUT];
  assign uf_t4 = (t4_zero_rise & ~t4_ext_now) | (t4_ext_pend_q & (t4_half_q ? t4_rise : t4_fall));

  // start, stop now or at high-phase underflow, count and alternate reload
  always_ff @(posedge clock) begin
    if (srst) begin
      t4_run_prev_q <= 1'b0;
      t4_active_q   <= 1'b0;
      t4_armed_q    <= 1'b0;
      t4_high_q     <= 1'b0;
      t4_ext_pend_q <= 1'b0;
      t4_half_q     <= 1'b0;
      t4_cnt_q      <= tpw_pkg::RELOAD_RESET;
    end else begin
      t4_run_prev_q <= fourth_timer_ctrl_q[tpw_pkg::T4_RUN];
      if (!t4_active_q) begin
        t4_cnt_q  <= low_phase_reload_q;
        t4_high_q <= 1'b0;
        t4_armed_q <= 1'b0;
        t4_half_q  <= 1'b0;
        if (fourth_timer_ctrl_q[tpw_pkg::T4_RUN] && !t4_run_prev_q) t4_active_q <= 1'b1;
      end else if (!t4_armed_q) begin
        if (t4_fall) t4_armed_q <= 1'b1;
      end else if (!fourth_timer_ctrl_q[tpw_pkg::T4_RUN] && !t4_high_q) begin
        t4_active_q <= 1'b0;  // low phase or plain timer: stop now
      end else if (uf_t4) begin
        t4_ext_pend_q <= 1'b0;
        if (t4_ext_pend_q) t4_half_q <= ~t4_half_q;  // next phase keeps whole periods
        if (!fourth_timer_ctrl_q[tpw_pkg::T4_RUN]) t4_active_q <= 1'b0;
        if (fourth_timer_ctrl_q[tpw_pkg::T4_PWM_OUT] && !t4_high_q) begin
          t4_cnt_q  <= high_phase_reload_q;
          t4_high_q <= 1'b1;
        end else begin
          t4_cnt_q  <= low_phase_reload_q;
          t4_high_q <= 1'b0;
        end
      end else if (t4_zero_rise) begin
        t4_ext_pend_q <= 1'b1;  // half period more
      end else if (t4_tick && !t4_ext_pend_q) begin
        t4_cnt_q <= t4_cnt_q - 8'h01;
      end
    end
  end

  // ****************************************************************
  // timer 3 gating of the pwm output
  // ****************************************************************
  assign gate_active = pin_edge_ctrl_q[tpw_pkg::PE_T3_GATE] & third_timer_ctrl_q[tpw_pkg::TC_RUN];

  always_ff @(posedge clock) begin
    if (srst) begin
      pass_q <= 1'b0;
    end else if (!gate_active) begin
      pass_q <= 1'b0;
    end else if (uf_t3) begin
      pass_q <= ~pass_q;
    end
  end

  // divided underflow for pin a
  always_ff @(posedge clock) begin
    if (srst) begin
      div_a_q <= 1'b0;
    end else if (second_timer_ctrl_q[tpw_pkg::TC_OUT_SEL_T2] ? uf_t2 : uf_t1) begin
      div_a_q <= ~div_a_q;
    end
  end

  // ****************************************************************
  // pin drivers
  // ****************************************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_a_out_q <= 1'b0;
      pin_a_oe_q  <= 1'b0;
      pin_b_out_q <= 1'b0;
      pin_b_oe_q  <= 1'b0;
    end else begin
      pin_a_oe_q  <= pin_edge_ctrl_q[tpw_pkg::PE_PIN_A_OUT];
      pin_a_out_q <= div_a_q;
      pin_b_oe_q  <= fourth_timer_ctrl_q[tpw_pkg::T4_PWM_OUT];
      pin_b_out_q <= t4_active_q & t4_armed_q & t4_high_q & (pass_q | ~gate_active);
    end
  end

  assign timer_io_pin_a_out = pin_a_out_q;
  assign timer_io_pin_a_oe  = pin_a_oe_q;
  assign timer_io_pin_b_out = pin_b_out_q;
  assign timer_io_pin_b_oe  = pin_b_oe_q;

endmodule : tpw_top
`default_nettype wire

// [verif/tpw_top_asserts.sv]
// checker of bus handshake, pin enables and flag clearing
// assumes it is bound into tpw_top, one clock domain
`timescale 1ns/1ps
`default_nettype none
module tpw_chk (
  // clock, reset, bus and pins
  input wire logic        clock, srst, read, write, waitrequest,
  input wire logic [5:0]  address,
  input wire logic [3:0]  byteenable, irq_taken, timer_flags,
  input wire logic [31:0] writedata, readdata,
  input wire logic        timer_io_pin_a_oe, timer_io_pin_b_oe
);
  wire logic wacc = write && !waitrequest && byteenable[0];
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // one wait cycle per request
  a_wait_one: assert property ((read || write) && waitrequest |=> !waitrequest)
    else $error("request not answered");
  a_wait_pulse: assert property (!waitrequest |=> waitrequest)
    else $error("wait low too long");
  a_wait_cause: assert property ($fell(waitrequest) |-> $past(read || write))
    else $error("answer without request");
  a_unmapped_zero: assert property (read && !waitrequest && address == 6'h3C |-> readdata == 32'h0)
    else $error("unmapped read not zero");
  // pin roles follow their control bits
  a_pin_a_role: assert property (wacc && address == 6'h00 |-> ##2 timer_io_pin_a_oe == $past(writedata[0], 2))
    else $error("pin a enable wrong");
  a_pin_b_role: assert property (wacc && address == 6'h08 |-> ##2 timer_io_pin_b_oe == $past(writedata[3], 2))
    else $error("pin b enable wrong");
  // timer 1 and timer 3 flags fall only when cleared
  a_flag_t1_hold: assert property ($fell(timer_flags[0]) |->
    $past(irq_taken[0] || srst || wacc && address == 6'h2C && writedata[0])) else $error("t1 flag lost");
  a_flag_t3_hold: assert property ($fell(timer_flags[2]) |->
    $past(irq_taken[2] || srst || wacc && address == 6'h2C && writedata[2])) else $error("t3 flag lost");
endmodule : tpw_chk
bind tpw_top tpw_chk chk (.clock, .srst, .read, .write, .waitrequest, .address, .byteenable, .irq_taken,
  .timer_flags, .writedata, .readdata, .timer_io_pin_a_oe, .timer_io_pin_b_oe);
`default_nettype wire

// [verif/tpw_pin_src.sv]
// square-wave source standing in for a pulse device on a timer pin
// assumes the line is pulled low while the source is idle
`timescale 1ns/1ps
`default_nettype none
module tpw_pin_src (
  input  wire logic       clock,
  input  wire logic       en,
  input  wire logic [3:0] half,
  output logic            pin
);
  logic [3:0] cnt_q;
  // toggle after half plus one clocks, else sit at pull-down level
  always_ff @(posedge clock) begin
    cnt_q <= (!en || cnt_q == half) ? 4'h0 : cnt_q + 4'h1;
    pin   <= en && (cnt_q == half ? !pin : pin);
  end
endmodule : tpw_pin_src
`default_nettype wire

// [verif/timer_pin_and_pwm_output_test.sv]
// bench: register bus, timer flags, pin roles and pwm phases
// assumes tpw_top and tpw_pin_src, 40 MHz clock
`timescale 1ns/1ps
`default_nettype none
module timer_pin_and_pwm_output_test;
  logic        clock = 1'b0, srst = 1'b1, read = 1'b0, write = 1'b0, src_en = 1'b0, prev;
  logic [5:0]  address = 6'h00;
  logic [3:0]  byteenable = 4'h1, irq_taken = 4'h0, timer_flags;
  logic [31:0] writedata = 32'h0, readdata, d;
  logic        waitrequest, a_out, a_oe, b_out, b_oe, src_pin;
  logic [63:0] exp_q[$];
  int          n_errors = 0, checked = 0, n;
  wire logic   pin_a = a_oe ? a_out : src_pin;
  wire logic   pin_b = b_oe ? b_out : src_pin;
  tpw_top uut (.clock, .srst, .address, .read, .write, .byteenable, .writedata, .readdata, .waitrequest,
    .timer_io_pin_a_in(pin_a), .timer_io_pin_a_out(a_out), .timer_io_pin_a_oe(a_oe), .irq_taken,
    .timer_io_pin_b_in(pin_b), .timer_io_pin_b_out(b_out), .timer_io_pin_b_oe(b_oe), .timer_flags);
  tpw_pin_src src (.clock, .en(src_en), .half(4'h3), .pin(src_pin));
  always #12.5 clock = ~clock;
  task automatic check(input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] v);
    @(posedge clock);
    read <= !wr;
    write <= wr;
    address <= a;
    writedata <= v;
    do @(posedge clock); while (waitrequest !== 1'b0);
    read <= 1'b0;
    write <= 1'b0;
  endtask : bus
  task automatic rd(input logic [5:0] a, input logic [31:0] m, e);
    exp_q.push_back({m, e});
    bus(1'b0, a, 32'h0);
  endtask : rd
  // length of one full phase at level lv on pin b or pin a
  task automatic phase(input logic b, lv, input int exp);
    int c;
    c = 0;
    @(posedge clock iff (b ? b_out : a_out) !== lv);
    @(posedge clock iff (b ? b_out : a_out) === lv);
    while ((b ? b_out : a_out) === lv) begin
      @(posedge clock);
      c++;
    end
    check(c, exp);
  endtask : phase
  // count source edges of one direction until timer flag f rises
  task automatic count_edges(input int f, input logic fall, input int exp);
    n = 0;
    prev = src_pin;
    src_en <= 1'b1;
    while (timer_flags[f] !== 1'b1) begin
      @(posedge clock);
      if (prev === fall && src_pin === !fall) n++;
      prev = src_pin;
    end
    check(n, exp);
  endtask : count_edges
  task automatic report_and_stop();
    if (n_errors == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop
  // compare read data with the oldest note
  always @(posedge clock) begin
    if (read && waitrequest === 1'b0) begin
      check(readdata & exp_q[0][63:32], exp_q[0][31:0]);
      void'(exp_q.pop_front());
    end
  end
  // watchdog
  initial begin
    #40000;
    n_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    void'($urandom(32'hD8E9D9F9));
    repeat (16) @(posedge clock);
    srst <= 1'b0;
    for (int a = 0; a < 64; a += 4) rd(a, 32'hF, 32'h0);
    for (int a = 24; a < 44; a += 4) begin
      d = $urandom() & 32'hFF;
      bus(1'b1, a, d);
      rd(a, 32'hFF, d);
    end
    bus(1'b1, 6'h18, 32'h3);
    bus(1'b1, 6'h00, 32'h1);
    bus(1'b1, 6'h10, 32'h4);
    phase(1'b0, 1'b1, 4);
    rd(6'h2C, 32'h1, 32'h1);
    bus(1'b1, 6'h10, 32'h0);
    bus(1'b1, 6'h2C, 32'h1);
    rd(6'h2C, 32'h1, 32'h0);
    bus(1'b1, 6'h00, 32'h8);
    bus(1'b1, 6'h20, 32'h2);
    bus(1'b1, 6'h04, 32'h5);
    count_edges(2, 1'b1, 3);
    bus(1'b1, 6'h04, 32'h0);
    src_en <= 1'b0;
    irq_taken <= 4'h4;
    @(posedge clock);
    irq_taken <= 4'h0;
    rd(6'h2C, 32'h4, 32'h0);
    bus(1'b1, 6'h24, 32'h2);
    bus(1'b1, 6'h28, 32'h3);
    bus(1'b1, 6'h08, 32'hA);
    phase(1'b1, 1'b1, 8);
    phase(1'b1, 1'b0, 6);
    bus(1'b1, 6'h08, 32'hE);
    phase(1'b1, 1'b1, 9);
    phase(1'b1, 1'b0, 6);
    bus(1'b1, 6'h0C, 32'h4);
    bus(1'b1, 6'h10, 32'h4);
    count_edges(0, 1'b0, 2);
    rd(6'h2C, 32'h41, 32'h41);
    src_en <= 1'b0;
    bus(1'b1, 6'h10, 32'h0);
    bus(1'b1, 6'h0C, 32'h0);
    bus(1'b1, 6'h2C, 32'h1);
    rd(6'h2C, 32'h41, 32'h0);
    report_and_stop();
  end
endmodule : timer_pin_and_pwm_output_test
`default_nettype wire
